// File: design/dtc_map.svh
// Constants for the dual timer/counter: mode codes, field positions and
// timing counts. Assumes the core clock stands in for the oscillator.
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH
`define DTC_MODE_PRESCALE 2'h0
`define DTC_MODE_SIXTEEN  2'h1
`define DTC_MODE_RELOAD   2'h2
`define DTC_MODE_SPLIT    2'h3
`define DTC_OSC_PER_MC    6
`define DTC_PRESCALE_DIV  32
`define DTC_MODE_LO_BIT   0
`define DTC_MODE_HI_BIT   1
`define DTC_SRC_BIT       2
`define DTC_GATE_BIT      3
`define DTC_COUNT_RST     16'h0000
`endif

// File: design/dtc_pkg.sv
// Types shared by the dual timer/counter.
// Assumes the map header provides the numeric constants.
package dtc_pkg;
  // One unit's four configuration bits, as in the timer mode register nibble.
  typedef struct packed {
    logic       gate_en;
    logic       count_src;
    logic [1:0] mode;
  } dtc_cfg_s;
endpackage : dtc_pkg

// File: design/dtc_timer.sv
// Two timer/counter units with machine-cycle timing and pin edge detection.
// Assumes count and gate pins are asynchronous; core_clk is the oscillator.
`timescale 1ns/10ps
`default_nettype none
`include "dtc_map.svh"
module dtc_timer
#(
  parameter int OSC_PER_MC   = `DTC_OSC_PER_MC,
  parameter int PRESCALE_DIV = `DTC_PRESCALE_DIV
)
(
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire dtc_pkg::dtc_cfg_s cfg_zero,
  input  wire dtc_pkg::dtc_cfg_s cfg_one,
  input  wire logic [1:0]       run_en,
  input  wire logic             count_input_zero,
  input  wire logic             count_input_one,
  input  wire logic             gate_input_zero,
  input  wire logic             gate_input_one,
  input  wire logic [1:0]       load_stb,
  input  wire logic [15:0]      load_val,
  input  wire logic [7:0]       reload_zero,
  input  wire logic [7:0]       reload_one,
  output logic      [15:0]      count_zero,
  output logic      [15:0]      count_one,
  output logic                  mc_tick
);
  localparam int MCW = $clog2(OSC_PER_MC);
  localparam int PSW = $clog2(PRESCALE_DIV);
  localparam logic [MCW-1:0] MC_LAST = MCW'(OSC_PER_MC - 1);

  logic [MCW-1:0] mc_reg;
  logic [1:0]     cnt_s1_reg, cnt_s2_reg, cnt_smp_reg;
  logic [1:0]     gate_s1_reg, gate_s2_reg;
  logic [15:0]    cnt_reg [2];
  logic [1:0]     fall;
  logic           mc_end;
  dtc_pkg::dtc_cfg_s cfg [2];

  assign cfg[0] = cfg_zero;
  assign cfg[1] = cfg_one;
  assign mc_end = (mc_reg == MC_LAST);

  // Machine-cycle divider: one enable pulse every six core clocks.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      mc_reg <= '0;
    else if (mc_end)
      mc_reg <= '0;
    else
      mc_reg <= mc_reg + MCW'(1);
  end

  // Two-flop synchronisers for the asynchronous pins.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cnt_s1_reg  <= 2'h3;
      cnt_s2_reg  <= 2'h3;
      gate_s1_reg <= 2'h0;
      gate_s2_reg <= 2'h0;
    end
    else
    begin
      cnt_s1_reg  <= {count_input_one, count_input_zero};
      cnt_s2_reg  <= cnt_s1_reg;
      gate_s1_reg <= {gate_input_one, gate_input_zero};
      gate_s2_reg <= gate_s1_reg;
    end
  end

  // Count pins are sampled once per machine cycle; a fall is a high
  // sample followed by a low one, so recognition takes two cycles and a
  // source faster than osc/12 loses edges.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      cnt_smp_reg <= 2'h3;
    else if (mc_end)
      cnt_smp_reg <= cnt_s2_reg;
  end
  assign fall = cnt_smp_reg & ~cnt_s2_reg & {2{mc_end}};

  // Per-unit counting.
  for (genvar u = 0; u < 2; u++)
  begin : g_unit
    logic [PSW-1:0] pre;
    logic [7:0]     hi;
    logic           ev;
    logic           ok;
    logic           stop;
    logic           pre_carry;
    assign pre  = cnt_reg[u][PSW-1:0];
    assign hi   = cnt_reg[u][15:8];
    // Source: machine cycle or a detected pin fall.
    assign ev   = cfg[u].count_src ? fall[u] : mc_end;
    // Gate pin lets counting run only while high when gating is on.
    assign ok   = run_en[u] & (~cfg[u].gate_en | gate_s2_reg[u]);
    // Unit 1 halts whenever unit 0 is split.
    assign stop = (u == 1) && (cfg[0].mode == `DTC_MODE_SPLIT);
    assign pre_carry = (pre == PSW'(PRESCALE_DIV - 1));

    always_ff @(posedge core_clk)
    begin
      if (!rst_n)
        cnt_reg[u] <= `DTC_COUNT_RST;
      else if (load_stb[u])
        cnt_reg[u] <= load_val;
      else
      begin
        // Low byte / prescaler, gated by this unit's own controls and, for unit 1, by unit 0's split mode.
        if (ev && ok && !stop)
        begin
          case (cfg[u].mode)
            `DTC_MODE_PRESCALE:
            begin
              // Low five bits prescale, high byte is the 8-bit counter.
              cnt_reg[u][PSW-1:0] <= pre + PSW'(1);
              if (pre_carry)
                cnt_reg[u][15:8] <= hi + 8'h01;
            end
            `DTC_MODE_SIXTEEN:
              cnt_reg[u] <= cnt_reg[u] + 16'h0001;
            `DTC_MODE_RELOAD:
            begin
              if (cnt_reg[u][7:0] == 8'hff)
                cnt_reg[u][7:0] <= (u == 0) ? reload_zero
                                            : reload_one;
              else
                cnt_reg[u][7:0] <= cnt_reg[u][7:0] + 8'h01;
            end
            default:
              cnt_reg[u][7:0] <= cnt_reg[u][7:0] + 8'h01;
          endcase
        end
        // Split mode: unit 0's high byte is a timer run by unit 1's enable.
        if (u == 0 && cfg[0].mode == `DTC_MODE_SPLIT && mc_end && run_en[1])
          cnt_reg[u][15:8] <= hi + 8'h01;
      end
    end
  end

  // Registered outputs.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      count_zero <= `DTC_COUNT_RST;
      count_one  <= `DTC_COUNT_RST;
      mc_tick    <= 1'b0;
    end
    else
    begin
      count_zero <= cnt_reg[0];
      count_one  <= cnt_reg[1];
      mc_tick    <= mc_end;
    end
  end

  // Most checks watch unit 0; unit 1 is the same generate body, so only
  // the split halt and the counter source are watched on unit 1, where
  // the two units really differ.

  // A prescaled unit's high byte steps only on a prescaler carry.
  a_prescale_step: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (cfg_zero.mode == `DTC_MODE_PRESCALE && !load_stb[0]
     && cnt_reg[0][PSW-1:0] != PSW'(PRESCALE_DIV - 1))
    |=> $stable(cnt_reg[0][15:8]))
    else $error("prescaled high byte moved without carry");
  // Split mode freezes unit 1.
  a_split_halt: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (cfg_zero.mode == `DTC_MODE_SPLIT && !load_stb[1])
    |=> $stable(cnt_reg[1]))
    else $error("unit one counted while unit zero split");
  // In split mode unit 0's high byte counts machine cycles on unit 1's run.
  a_split_timer: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (cfg_zero.mode == `DTC_MODE_SPLIT && mc_end && run_en[1] && !load_stb[0])
    |=> cnt_reg[0][15:8] == $past(cnt_reg[0][15:8]) + 8'h01)
    else $error("split high-byte timer did not step");
  // Machine cycles are six clocks apart. The repetition is written for the
  // default divider; a different OSC_PER_MC needs this count changed too.
  a_mc_period: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    mc_end |=> !mc_end [*5] ##1 mc_end)
    else $error("machine cycle not six clocks");
  // A closed gate holds unit 0 outside split mode.
  a_gate_hold: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (cfg_zero.gate_en && !gate_s2_reg[0] && !load_stb[0]
     && cfg_zero.mode != `DTC_MODE_SPLIT) |=> $stable(cnt_reg[0]))
    else $error("gated unit counted with gate low");
  // Timer source counts in 16-bit mode once per machine cycle.
  a_timer_inc: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (cfg_zero.mode == `DTC_MODE_SIXTEEN && !cfg_zero.count_src
     && run_en[0] && !cfg_zero.gate_en && mc_end && !load_stb[0])
    |=> cnt_reg[0] == $past(cnt_reg[0]) + 16'h0001)
    else $error("sixteen-bit timer did not step");
  // Counter source only steps on a falling sample.
  a_edge_only: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (cfg_one.count_src && !fall[1] && !load_stb[1]) |=> $stable(cnt_reg[1]))
    else $error("counter stepped without falling edge");
  // Reload wraps to the holding value.
  a_reload_wrap: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (cfg_zero.mode == `DTC_MODE_RELOAD && g_unit[0].ev && g_unit[0].ok
     && cnt_reg[0][7:0] == 8'hff && !load_stb[0])
    |=> cnt_reg[0][7:0] == $past(reload_zero))
    else $error("reload value not taken on overflow");
  // A sixteen-bit unit carries its low byte into the high byte.
  a_wide_carry: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (cfg_zero.mode == `DTC_MODE_SIXTEEN && g_unit[0].ev && g_unit[0].ok
     && cnt_reg[0][7:0] == 8'hff && !load_stb[0])
    |=> cnt_reg[0][15:8] == $past(cnt_reg[0][15:8]) + 8'h01)
    else $error("sixteen-bit carry into high byte lost");
endmodule : dtc_timer
`default_nettype wire

// File: tb/dtc_pin_model.sv
// Far-side model of the count and gate pins of both units.
// Assumes the bench calls its tasks; pins idle high as pull-ups leave them.
`timescale 1ns/10ps
`default_nettype none
module dtc_pin_model
(
  input  wire logic core_clk,
  output var logic  count_input_zero,
  output var logic  count_input_one,
  output var logic  gate_input_zero,
  output var logic  gate_input_one
);
  // Idle levels at time zero.
  initial
  begin
    count_input_zero = 1'b1;
    count_input_one = 1'b1;
    gate_input_zero = 1'b1;
    gate_input_one = 1'b1;
  end

  // Each level stands 12 clocks, so no edge comes faster than osc/12.
  task automatic falls_one(input int n);
    repeat (n)
    begin
      repeat (12) @(negedge core_clk);
      count_input_one = 1'b0;
      repeat (12) @(negedge core_clk);
      count_input_one = 1'b1;
    end
    repeat (24) @(negedge core_clk);
  endtask : falls_one

  // Same spacing on unit 0's count pin.
  task automatic falls_zero(input int n);
    repeat (n)
    begin
      repeat (12) @(negedge core_clk);
      count_input_zero = 1'b0;
      repeat (12) @(negedge core_clk);
      count_input_zero = 1'b1;
    end
    repeat (24) @(negedge core_clk);
  endtask : falls_zero

  // Sets the gate level of unit 1.
  task automatic gate_one(input logic v);
    @(negedge core_clk);
    gate_input_one = v;
  endtask : gate_one

  // Sets the gate level of unit 0.
  task automatic gate_zero(input logic v);
    @(negedge core_clk);
    gate_input_zero = v;
  endtask : gate_zero
endmodule : dtc_pin_model
`default_nettype wire

// File: tb/dtc_timer_bench.sv
// Bench for the dual timer/counter: scenario calls with expected counts.
// Assumes the pin model drives all count and gate pins.
`timescale 1ns/10ps
`default_nettype none
module dtc_timer_bench;
  logic              core_clk;
  logic              rst_n;
  dtc_pkg::dtc_cfg_s cfg_zero;
  dtc_pkg::dtc_cfg_s cfg_one;
  logic [1:0]        run_en;
  logic [1:0]        load_stb;
  logic [15:0]       load_val;
  logic [15:0]       count_zero;
  logic [15:0]       count_one;
  logic              mc_tick;
  logic [7:0]        reload_zero;
  logic [7:0]        reload_one;
  wire logic         cin0;
  wire logic         cin1;
  wire logic         gin0;
  wire logic         gin1;
  int                err_count = 0;
  int                n_checks = 0;
  int                n_tick = 0;

  dtc_pin_model pins (.core_clk(core_clk), .count_input_zero(cin0),
    .count_input_one(cin1), .gate_input_zero(gin0), .gate_input_one(gin1));
  dtc_timer uut (.core_clk(core_clk), .rst_n(rst_n), .cfg_zero(cfg_zero),
    .cfg_one(cfg_one), .run_en(run_en), .count_input_zero(cin0),
    .count_input_one(cin1), .gate_input_zero(gin0), .gate_input_one(gin1),
    .load_stb(load_stb), .load_val(load_val), .reload_zero(reload_zero),
    .reload_one(reload_one), .count_zero(count_zero), .count_one(count_one),
    .mc_tick(mc_tick));

  // Free-running 100 MHz clock.
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Loads the units in mask m; a one-cycle strobe, as the loader expects.
  task automatic load(input logic [1:0] m, input logic [15:0] v);
    @(negedge core_clk);
    load_val = v;
    load_stb = m;
    @(negedge core_clk);
    load_stb = 2'h0;
  endtask : load

  // Whole machine cycles only, so the start phase cannot change the count.
  task automatic run(input logic [1:0] m, input int mc);
    @(negedge core_clk);
    run_en = m;
    repeat (6 * mc) @(negedge core_clk);
    run_en = 2'h0;
    repeat (3) @(negedge core_clk);
  endtask : run

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t: count %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // Hang guard, well past the 1250 or so cycles the tests need.
  initial
  begin
    #200000;
    err_count++;
    print_verdict();
  end

  // Scenarios, one mode or function each.
  initial
  begin
    rst_n = 1'b0;
    cfg_zero = '0;
    cfg_one = '0;
    run_en = 2'h0;
    load_stb = 2'h0;
    load_val = 16'h0000;
    reload_zero = 8'h80;
    reload_one = 8'h40;
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    chk(count_zero, 16'h0000);
    chk(count_one, 16'h0000);
    // Sixty clocks hold exactly ten one-clock machine-cycle pulses.
    repeat (60)
    begin
      @(negedge core_clk);
      if (mc_tick === 1'b1)
        n_tick++;
    end
    chk(16'(n_tick), 16'h000a);
    cfg_zero = '{1'b0, 1'b0, 2'h1};
    load(2'h1, 16'h00fe);
    run(2'h1, 5);
    chk(count_zero, 16'h0103);
    cfg_zero = '{1'b0, 1'b0, 2'h0};
    load(2'h1, 16'h0000);
    run(2'h1, 96);
    chk({count_zero[15:8], 3'h0, count_zero[4:0]}, 16'h0300);
    cfg_zero = '{1'b0, 1'b0, 2'h2};
    load(2'h1, 16'h00fe);
    run(2'h1, 4);
    chk({8'h00, count_zero[7:0]}, 16'h0082);
    // Unit 1 reloads from its own holding value.
    cfg_one = '{1'b0, 1'b0, 2'h2};
    load(2'h2, 16'h00fd);
    run(2'h2, 5);
    chk(count_one, 16'h0042);
    cfg_zero = '{1'b0, 1'b0, 2'h3};
    cfg_one = '{1'b0, 1'b0, 2'h1};
    load(2'h1, 16'h0000);
    load(2'h2, 16'h1234);
    run(2'h3, 5);
    chk(count_zero, 16'h0505);
    chk(count_one, 16'h1234);
    cfg_zero = '{1'b0, 1'b0, 2'h1};
    cfg_one = '{1'b0, 1'b1, 2'h1};
    load(2'h2, 16'h0000);
    run_en = 2'h2;
    pins.falls_one(4);
    run(2'h0, 1);
    chk(count_one, 16'h0004);
    // Unit 0 counts its own pin, not unit 1's.
    cfg_zero = '{1'b0, 1'b1, 2'h1};
    load(2'h1, 16'h0000);
    run_en = 2'h1;
    pins.falls_zero(3);
    run(2'h0, 1);
    chk(count_zero, 16'h0003);
    chk(count_one, 16'h0004);
    cfg_zero = '{1'b1, 1'b0, 2'h1};
    pins.gate_zero(1'b0);
    load(2'h1, 16'h0000);
    run(2'h1, 10);
    chk(count_zero, 16'h0000);
    pins.gate_zero(1'b1);
    repeat (20) @(negedge core_clk);
    run(2'h1, 7);
    chk(count_zero, 16'h0007);
    // Unit 1 has a gate of its own.
    cfg_one = '{1'b1, 1'b0, 2'h1};
    pins.gate_one(1'b0);
    load(2'h2, 16'h0000);
    run(2'h2, 4);
    chk(count_one, 16'h0000);
    pins.gate_one(1'b1);
    repeat (20) @(negedge core_clk);
    run(2'h2, 4);
    chk(count_one, 16'h0004);
    print_verdict();
  end
endmodule : dtc_timer_bench
`default_nettype wire
